// >>> inc/hdmb_defs.svh
`ifndef HDMB_DEFS_SVH
`define HDMB_DEFS_SVH

// ----------------------------------------------------------------
// i/o ports and host field positions
// ----------------------------------------------------------------
`define HDMB_PORT_UPPER_ADDR   16'h0336
`define HDMB_PORT_MODE         16'h033c
`define HDMB_UPPER_ADDR_W      4
`define HDMB_MODE_LSB          9
`define HDMB_MODE_MSB          10
`define HDMB_STEER_BIT         16

// ----------------------------------------------------------------
// queue geometry defaults
// ----------------------------------------------------------------
`define HDMB_QDEPTH_LOG2       12
`define HDMB_BYTE_W            8
`define HDMB_BANK_BYTES        3
`define HDMB_DATA_QUEUES       6
`define HDMB_ADDR_Q_W          17
`define HDMB_LANES             8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HDMB_UPPER_ADDR_RST    4'h0
`define HDMB_SYNC_RST          3'h7

`endif

// >>> inc/hdmb_pkg.sv
package hdmb_pkg;

    // transfer mode, in code order 00..11
    typedef enum logic [1:0] {
        HDMB_WORD_WR,
        HDMB_WORD_RD,
        HDMB_BYTE_RMW,
        HDMB_MASK_RMW
    } hdmb_mode_e;

    // which bank the board side currently presents
    typedef enum logic {
        HDMB_STEP_LOWER,
        HDMB_STEP_UPPER
    } hdmb_step_e;

    // memory access handshake state
    typedef enum logic [1:0] {
        HDMB_CYC_IDLE,
        HDMB_CYC_AVAIL,
        HDMB_CYC_RELEASE
    } hdmb_cyc_e;

endpackage : hdmb_pkg

// >>> rtl/hdmb_queue_ram.sv
`timescale 1ns/1ps
`default_nettype none

module hdmb_queue_ram #(
    parameter int WIDTH      = 8,
    parameter int DEPTH_LOG2 = 12
) (
    // clock
    input  wire logic                  ref_clk_in,
    // write side
    input  wire logic                  wr_en_in,
    input  wire logic [DEPTH_LOG2-1:0] wr_addr_in,
    input  wire logic [WIDTH-1:0]      wr_data_in,
    // read side
    input  wire logic                  rd_en_in,
    input  wire logic [DEPTH_LOG2-1:0] rd_addr_in,
    output logic      [WIDTH-1:0]      rd_data_out
);

    // ----------------------------------------------------------------
    // storage, no reset so it maps onto block ram
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] mem_reg [0:(1<<DEPTH_LOG2)-1];

    always_ff @(posedge ref_clk_in)
    begin
        if (wr_en_in)
        begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
        if (rd_en_in)
        begin
            rd_data_out <= mem_reg[rd_addr_in];
        end
    end

endmodule // hdmb_queue_ram

`default_nettype wire

// >>> rtl/hdmb_bridge.sv
`timescale 1ns/1ps
`default_nettype none
`include "hdmb_defs.svh"

module hdmb_bridge #(
    parameter int QDEPTH_LOG2 = `HDMB_QDEPTH_LOG2
) (
    // clock and reset
    input  wire logic                       ref_clk_in,
    input  wire logic                       reset_n_in,
    // host bus, same clock domain
    input  wire logic                       host_mem_wr_in,
    input  wire logic                       host_io_wr_in,
    input  wire logic [16:0]                host_addr_in,
    input  wire logic [15:0]                host_data_bus_in,
    input  wire logic                       host_byte_high_n_in,
    // load strobes and queue state
    output logic      [5:0]                 data_queue_load_out,
    output logic                            addr_queue_load_out,
    output logic      [6:0]                 queue_full_out,
    // display board side
    input  wire logic                       board_ready_in,
    output logic                            board_valid_out,
    output logic      [23:0]                board_data_bus_out,
    output logic                            lower_bank_read_out,
    output logic                            upper_bank_read_out,
    output logic                            board_addr_lsb_out,
    output logic      [16:0]                board_addr_upper_out,
    // display memory control
    input  wire logic                       data_ack_n_in,
    output logic                            addr_avail_n_out,
    output logic                            seq_enable_n_out,
    output logic                            mem_read_n_out,
    output logic                            half_select_n_out,
    output logic      [7:0]                 byte_lane_sel_n_out,
    output logic      [1:0]                 xfer_code_out,
    output logic                            mem_busy_out
);

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (QDEPTH_LOG2 < 2 || QDEPTH_LOG2 > 16)
    begin : g_depth_check
        $error("QDEPTH_LOG2 out of range");
    end

    localparam int NQ    = `HDMB_DATA_QUEUES + 1;
    localparam int BANKW = `HDMB_BYTE_W * `HDMB_BANK_BYTES;
    localparam int BUFW  = `HDMB_ADDR_Q_W + 2 * BANKW;

    typedef struct packed {
        logic [`HDMB_UPPER_ADDR_W-1:0]   upper_addr;
        hdmb_pkg::hdmb_mode_e            mode;
        logic [NQ-1:0][QDEPTH_LOG2:0]    wptr;
        logic [NQ-1:0][QDEPTH_LOG2:0]    rptr;
        logic                            rd_pending;
        logic [1:0][BUFW-1:0]            buf_data;
        logic [1:0]                      buf_cnt;
        hdmb_pkg::hdmb_step_e            step;
        logic [2:0]                      ack_sync;
        logic                            ack_n;
        hdmb_pkg::hdmb_cyc_e             cyc;
        logic [3:0]                      lane_addr;
    } hdmb_state_s;

    hdmb_state_s state_reg;
    hdmb_state_s state_next;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic q_full(input logic [QDEPTH_LOG2:0] w, input logic [QDEPTH_LOG2:0] r);
        q_full = (w[QDEPTH_LOG2] != r[QDEPTH_LOG2]) && (w[QDEPTH_LOG2-1:0] == r[QDEPTH_LOG2-1:0]);
    endfunction

    function automatic logic q_empty(input logic [QDEPTH_LOG2:0] w, input logic [QDEPTH_LOG2:0] r);
        q_empty = (w == r);
    endfunction

    // ----------------------------------------------------------------
    // load strobe decode
    // ----------------------------------------------------------------
    // addr[2:1] picks a byte pair; pair 2 also commits the address entry,
    // so a transfer is three pair writes ending at pair 2
    logic        board_wr;
    logic [1:0]  pair_sel;
    logic        lo_byte;
    logic        hi_byte;
    logic [5:0]  load_raw;
    logic [NQ-1:0] q_wr;
    logic [NQ-1:0] q_is_full;
    logic [NQ-1:0] q_is_empty;
    logic [5:0][7:0] byte_in;

    assign board_wr = host_mem_wr_in && !host_addr_in[`HDMB_STEER_BIT];
    assign pair_sel = host_addr_in[2:1];
    assign lo_byte  = !host_addr_in[0];
    assign hi_byte  = !host_byte_high_n_in;

    always_comb
    begin
        load_raw = 6'h00;
        if (board_wr && pair_sel != 2'h3)
        begin
            load_raw[{pair_sel, 1'b0}] = lo_byte;
            load_raw[{pair_sel, 1'b1}] = hi_byte;
        end
    end

    assign data_queue_load_out = load_raw;
    assign addr_queue_load_out = board_wr && pair_sel == 2'h2;

    always_comb
    begin
        for (int i = 0; i < NQ; i++)
        begin
            q_is_full[i]  = q_full(state_reg.wptr[i], state_reg.rptr[i]);
            q_is_empty[i] = q_empty(state_reg.wptr[i], state_reg.rptr[i]);
        end
        // a full queue ignores further load strobes
        q_wr = {addr_queue_load_out, load_raw} & ~q_is_full;
        for (int i = 0; i < 6; i++)
        begin
            byte_in[i] = i[0] ? host_data_bus_in[15:8] : host_data_bus_in[7:0];
        end
    end

    assign queue_full_out = q_is_full;

    // ----------------------------------------------------------------
    // queue storage
    // ----------------------------------------------------------------
    logic              unload;
    logic [5:0][7:0]   byte_out;
    logic [16:0]       addr_out;

    for (genvar g = 0; g < 6; g++)
    begin : g_data_q
        hdmb_queue_ram #(
            .WIDTH      (`HDMB_BYTE_W),
            .DEPTH_LOG2 (QDEPTH_LOG2)
        ) u_ram (
            .ref_clk_in  (ref_clk_in),
            .wr_en_in    (q_wr[g]),
            .wr_addr_in  (state_reg.wptr[g][QDEPTH_LOG2-1:0]),
            .wr_data_in  (byte_in[g]),
            .rd_en_in    (unload),
            .rd_addr_in  (state_reg.rptr[g][QDEPTH_LOG2-1:0]),
            .rd_data_out (byte_out[g])
        );
    end

    hdmb_queue_ram #(
        .WIDTH      (`HDMB_ADDR_Q_W),
        .DEPTH_LOG2 (QDEPTH_LOG2)
    ) u_addr_q (
        .ref_clk_in  (ref_clk_in),
        .wr_en_in    (q_wr[6]),
        .wr_addr_in  (state_reg.wptr[6][QDEPTH_LOG2-1:0]),
        .wr_data_in  ({state_reg.upper_addr[1:0], host_addr_in[15:1]}),
        .rd_en_in    (unload),
        .rd_addr_in  (state_reg.rptr[6][QDEPTH_LOG2-1:0]),
        .rd_data_out (addr_out)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic pop;
    logic io_upper;
    logic io_mode;
    logic mem_wr;

    // the buffer counts the read in flight, so a stall never overruns it
    assign unload   = (q_is_empty == '0)
                      && ({1'b0, state_reg.buf_cnt} + {2'b00, state_reg.rd_pending} < 3'h2);
    assign pop      = state_reg.buf_cnt != 2'h0 && state_reg.step == hdmb_pkg::HDMB_STEP_UPPER
                      && board_ready_in;
    assign io_upper = host_io_wr_in && host_addr_in[15:0] == `HDMB_PORT_UPPER_ADDR;
    assign io_mode  = host_io_wr_in && host_addr_in[15:0] == `HDMB_PORT_MODE;
    assign mem_wr   = host_mem_wr_in && host_addr_in[`HDMB_STEER_BIT];

    always_comb
    begin
        state_next            = state_reg;
        state_next.rd_pending = unload;
        state_next.ack_sync   = {state_reg.ack_sync[1:0], data_ack_n_in};
        if (state_reg.ack_sync[2] == state_reg.ack_sync[1])
        begin
            state_next.ack_n = state_reg.ack_sync[2];
        end

        if (io_upper)
        begin
            state_next.upper_addr = host_data_bus_in[`HDMB_UPPER_ADDR_W-1:0];
        end
        if (io_mode)
        begin
            state_next.mode = hdmb_pkg::hdmb_mode_e'(host_data_bus_in[`HDMB_MODE_MSB:`HDMB_MODE_LSB]);
        end

        for (int i = 0; i < NQ; i++)
        begin
            if (q_wr[i])
            begin
                state_next.wptr[i] = state_reg.wptr[i] + 1'b1;
            end
            if (unload)
            begin
                state_next.rptr[i] = state_reg.rptr[i] + 1'b1;
            end
        end

        // two-entry buffer, head in slot 0
        if (pop)
        begin
            state_next.buf_data[0] = state_reg.buf_data[1];
            state_next.buf_cnt     = state_reg.buf_cnt - 2'h1;
        end
        if (state_reg.rd_pending)
        begin
            state_next.buf_data[state_next.buf_cnt[0]] =
                {addr_out, byte_out[5], byte_out[3], byte_out[1], byte_out[4], byte_out[2], byte_out[0]};
            state_next.buf_cnt = state_next.buf_cnt + 2'h1;
        end

        // two-step unload, address held across both
        if (state_reg.buf_cnt != 2'h0 && board_ready_in)
        begin
            case (state_reg.step)
                hdmb_pkg::HDMB_STEP_LOWER: state_next.step = hdmb_pkg::HDMB_STEP_UPPER;
                hdmb_pkg::HDMB_STEP_UPPER: state_next.step = hdmb_pkg::HDMB_STEP_LOWER;
                default:                   state_next.step = hdmb_pkg::HDMB_STEP_LOWER;
            endcase
        end

        // memory access handshake
        case (state_reg.cyc)
            hdmb_pkg::HDMB_CYC_IDLE:
            begin
                if (mem_wr)
                begin
                    state_next.lane_addr = host_addr_in[3:0];
                    state_next.cyc       = hdmb_pkg::HDMB_CYC_AVAIL;
                end
            end
            hdmb_pkg::HDMB_CYC_AVAIL:
            begin
                if (!state_reg.ack_n)
                begin
                    state_next.cyc = hdmb_pkg::HDMB_CYC_RELEASE;
                end
            end
            hdmb_pkg::HDMB_CYC_RELEASE:
            begin
                if (state_reg.ack_n)
                begin
                    state_next.cyc = hdmb_pkg::HDMB_CYC_IDLE;
                end
            end
            default: state_next.cyc = hdmb_pkg::HDMB_CYC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_reg            <= '0;
            state_reg.upper_addr <= `HDMB_UPPER_ADDR_RST;
            state_reg.ack_sync   <= `HDMB_SYNC_RST;
            state_reg.ack_n      <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // board outputs
    // ----------------------------------------------------------------
    logic upper_step;
    assign upper_step           = state_reg.step == hdmb_pkg::HDMB_STEP_UPPER;
    assign board_valid_out      = state_reg.buf_cnt != 2'h0;
    assign lower_bank_read_out  = board_valid_out && !upper_step;
    assign upper_bank_read_out  = board_valid_out && upper_step;
    assign board_data_bus_out   = upper_step ? state_reg.buf_data[0][2*BANKW-1:BANKW]
                                             : state_reg.buf_data[0][BANKW-1:0];
    assign board_addr_lsb_out   = upper_step;
    assign board_addr_upper_out = state_reg.buf_data[0][BUFW-1:2*BANKW];

    // ----------------------------------------------------------------
    // memory control outputs
    // ----------------------------------------------------------------
    // modify and mask bytes go to the memory itself; it does the merge
    logic word_mode;
    assign word_mode        = state_reg.mode == hdmb_pkg::HDMB_WORD_WR || state_reg.mode == hdmb_pkg::HDMB_WORD_RD;
    assign mem_busy_out     = state_reg.cyc != hdmb_pkg::HDMB_CYC_IDLE;
    assign addr_avail_n_out = state_reg.cyc != hdmb_pkg::HDMB_CYC_AVAIL;
    assign seq_enable_n_out = 1'b1;
    assign mem_read_n_out   = !(mem_busy_out && state_reg.mode != hdmb_pkg::HDMB_WORD_WR);
    assign half_select_n_out = word_mode || !state_reg.lane_addr[3];
    assign xfer_code_out    = state_reg.mode;

    always_comb
    begin
        byte_lane_sel_n_out = 8'hff;
        if (state_reg.mode == hdmb_pkg::HDMB_BYTE_RMW)
        begin
            byte_lane_sel_n_out[state_reg.lane_addr[2:0]] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_steer_gate: assert property (host_addr_in[`HDMB_STEER_BIT] |-> (data_queue_load_out == 6'h00 && !addr_queue_load_out))
        else $error("board load strobe while steered to memory");
    a_upper_latch: assert property (io_upper |=> state_reg.upper_addr == $past(host_data_bus_in[`HDMB_UPPER_ADDR_W-1:0]))
        else $error("upper address not latched");
    a_mode_latch: assert property (io_mode |=> xfer_code_out == $past(host_data_bus_in[`HDMB_MODE_MSB:`HDMB_MODE_LSB]))
        else $error("mode code not latched");
    a_bank_excl: assert property (!(lower_bank_read_out && upper_bank_read_out))
        else $error("both bank reads active");
    a_step_order: assert property (lower_bank_read_out && board_ready_in |=>
                                   upper_bank_read_out && board_addr_lsb_out
                                   && $stable(board_addr_upper_out))
        else $error("upper step does not follow lower");
    a_buf_bound: assert property ({1'b0, state_reg.buf_cnt} + {2'b00, state_reg.rd_pending} <= 3'h2)
        else $error("buffer and read in flight exceed two entries");
    a_seq_high: assert property (seq_enable_n_out)
        else $error("sequential enable driven low");
    a_read_hold: assert property (mem_busy_out && state_reg.mode[1] |-> !mem_read_n_out)
        else $error("read line high in rmw cycle");
    a_lane_one: assert property (mem_busy_out && state_reg.mode == hdmb_pkg::HDMB_BYTE_RMW
                                 |-> $countones(~byte_lane_sel_n_out) == 1)
        else $error("byte rmw needs one lane");
    a_go_clear: assert property ($fell(state_reg.ack_n) && state_reg.cyc == hdmb_pkg::HDMB_CYC_AVAIL
                                 |=> addr_avail_n_out)
        else $error("ack did not clear go");

    c_two_step: cover property (lower_bank_read_out && board_ready_in ##1 upper_bank_read_out && board_ready_in);
    c_buf_full: cover property (state_reg.buf_cnt == 2'h2 && !board_ready_in);
    c_byte_rmw: cover property (!addr_avail_n_out && state_reg.mode == hdmb_pkg::HDMB_BYTE_RMW);

endmodule // hdmb_bridge

`default_nettype wire

// >>> bench/hdmb_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module hdmb_far_model (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic reset_n_in,
    // pacing set by the bench
    input  wire logic stall_in,
    input  wire logic slow_in,
    // display board side
    input  wire logic board_valid_in,
    output logic      board_ready_out,
    // memory handshake
    input  wire logic addr_avail_n_in,
    output logic      data_ack_n_out
);
    logic [2:0] wait_reg;

    // ------------------------------------------------
    // board pacing and memory acknowledge
    // ------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            board_ready_out <= 1'b0;
            data_ack_n_out  <= 1'b1;
            wait_reg        <= 3'h0;
        end
        else
        begin
            // slow pace drops ready in mid entry, between the two steps
            board_ready_out <= !stall_in && (!slow_in || !(board_ready_out && board_valid_in));
            // ack follows avail late in both directions, never early
            if (data_ack_n_out == addr_avail_n_in)
                wait_reg <= 3'h0;
            else if (wait_reg == (slow_in ? 3'h5 : 3'h1))
            begin
                data_ack_n_out <= addr_avail_n_in;
                wait_reg       <= 3'h0;
            end
            else
                wait_reg <= wait_reg + 3'h1;
        end
    end
    // sequential enable is never pulled here: this far side makes no sequential access
endmodule // hdmb_far_model

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] lane;
        logic       rd_n;
        logic       half_n;
        logic [7:0] lanes;
    } hdmb_row_s;

    logic        ref_clk_in = 1'b0, reset_n_in = 1'b0;
    logic        host_mem_wr_in = 1'b0, host_io_wr_in = 1'b0, host_byte_high_n_in = 1'b1;
    logic [16:0] host_addr_in = 17'h00000, board_addr_upper_out;
    logic [15:0] host_data_bus_in = 16'h0000;
    logic [5:0]  data_queue_load_out;
    logic [6:0]  queue_full_out;
    logic [23:0] board_data_bus_out;
    logic [7:0]  byte_lane_sel_n_out;
    logic [1:0]  xfer_code_out;
    logic        addr_queue_load_out, board_ready_in, board_valid_out, lower_bank_read_out;
    logic        upper_bank_read_out, board_addr_lsb_out, data_ack_n_in, addr_avail_n_out;
    logic        seq_enable_n_out, mem_read_n_out, half_select_n_out, mem_busy_out;
    logic        stall = 1'b0, slow = 1'b1;
    int          bad_count = 0, total_checks = 0, cycles = 0;
    hdmb_row_s   rows [8] = '{'{2'h0, 4'h5, 1'b1, 1'b1, 8'hff}, '{2'h1, 4'h9, 1'b0, 1'b1, 8'hff},
                              '{2'h2, 4'h3, 1'b0, 1'b1, 8'hf7}, '{2'h2, 4'hc, 1'b0, 1'b0, 8'hef},
                              '{2'h3, 4'ha, 1'b0, 1'b0, 8'hff}, '{2'h3, 4'h2, 1'b0, 1'b1, 8'hff},
                              '{2'h2, 4'h0, 1'b0, 1'b1, 8'hfe}, '{2'h2, 4'h1, 1'b0, 1'b1, 8'hfd}};

    hdmb_bridge #(.QDEPTH_LOG2(3)) hdmb_bridge_i (.ref_clk_in, .reset_n_in, .host_mem_wr_in,
        .host_io_wr_in, .host_addr_in, .host_data_bus_in, .host_byte_high_n_in, .data_queue_load_out,
        .addr_queue_load_out, .queue_full_out, .board_ready_in, .board_valid_out, .board_data_bus_out,
        .lower_bank_read_out, .upper_bank_read_out, .board_addr_lsb_out, .board_addr_upper_out,
        .data_ack_n_in, .addr_avail_n_out, .seq_enable_n_out, .mem_read_n_out, .half_select_n_out,
        .byte_lane_sel_n_out, .xfer_code_out, .mem_busy_out);
    hdmb_far_model hdmb_far_model_i (.ref_clk_in, .reset_n_in, .stall_in(stall), .slow_in(slow),
        .board_valid_in(board_valid_out), .board_ready_out(board_ready_in),
        .addr_avail_n_in(addr_avail_n_out), .data_ack_n_out(data_ack_n_in));

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    always #2 ref_clk_in = ~ref_clk_in;

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // a hang is cut short at 5000 cycles, well past the few hundred cycles the run needs
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            $display("[ERR] %0t run did not complete", $time);
            finish_test;
        end
    end

    task chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] bt(input int i, input int p, input logic h);
        return {i[4:0], p[1:0], h};
    endfunction

    task hwr(input logic io, input logic [16:0] a, input logic [15:0] d, input logic bhn, input logic [6:0] s);
        host_io_wr_in       = io;
        host_mem_wr_in      = !io;
        host_addr_in        = a;
        host_data_bus_in    = d;
        host_byte_high_n_in = bhn;
        #1;
        chk({17'h0, addr_queue_load_out, data_queue_load_out}, {17'h0, s}, "strobes");
        @(posedge ref_clk_in);
        #1;
    endtask

    task idle;
        host_io_wr_in  = 1'b0;
        host_mem_wr_in = 1'b0;
    endtask

    task send(input int i);
        for (int p = 0; p < 3; p++)
            hwr(0, {9'h0, i[4:0], p[1:0], 1'b0}, {bt(i, p, 1), bt(i, p, 0)}, 0, 7'(3 << 2 * p) | (p == 2 ? 7'h40 : 7'h0));
        idle;
    endtask

    task step(input logic up, input int i);
        int n;
        n = 0;
        do @(negedge ref_clk_in); while (!(board_valid_out === 1'b1 && board_ready_in === 1'b1) && ++n < 200);
        chk({21'h0, lower_bank_read_out, upper_bank_read_out, board_addr_lsb_out}, {21'h0, !up, up, up}, "step");
        chk(board_data_bus_out, {bt(i, 2, up), bt(i, 1, up), bt(i, 0, up)}, "bank");
        chk({7'h0, board_addr_upper_out}, {9'h2, 8'h0, i[4:0], 2'h2}, "addr");
        @(posedge ref_clk_in);
        #1;
    endtask

    task mchk(input int r);
        chk({10'h0, xfer_code_out, addr_avail_n_out, seq_enable_n_out, mem_read_n_out, half_select_n_out,
            byte_lane_sel_n_out}, {10'h0, rows[r].mode, 2'b01, rows[r].rd_n, rows[r].half_n, rows[r].lanes}, "mode");
    endtask

    // the first reset has no falling edge, so outputs are looked at only after clock edges in reset
    task rst(input int n);
        reset_n_in = 1'b0;
        repeat (n) @(posedge ref_clk_in);
        #1;
        chk({9'h0, board_valid_out, addr_avail_n_out, seq_enable_n_out, mem_read_n_out, half_select_n_out,
            byte_lane_sel_n_out, xfer_code_out}, 24'h003ffc, "reset");
        reset_n_in = 1'b1;
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        rst(6);
        $display("test reset done");
        for (int r = 0; r < 8; r++)
        begin
            hwr(1, 17'h0033c, {5'h0, rows[r].mode, 9'h05a}, 0, 7'h0);
            // lane 0 carries the modify byte alone, every other lane the mask byte on the upper half
            hwr(0, {13'h1000, rows[r].lane}, 16'h1234, rows[r].lane == 4'h0, 7'h0);
            idle;
            #1;
            mchk(r);
            // a second go while busy must leave the lanes alone
            hwr(0, 17'h1000f, 16'h1234, 0, 7'h0);
            idle;
            mchk(r);
            for (int n = 0; n < 60 && mem_busy_out !== 1'b0; n++)
            begin
                @(posedge ref_clk_in);
                #1;
            end
            chk({21'h0, mem_busy_out, addr_avail_n_out, mem_read_n_out}, 24'h3, "release");
        end
        $display("test modes done");
        hwr(1, 17'h00336, 16'hfff2, 0, 7'h0);
        send(0);
        step(0, 0);
        step(1, 0);
        $display("test single transfer done");
        hwr(1, 17'h00337, 16'h0001, 0, 7'h0);
        stall = 1'b1;
        for (int i = 1; i <= 10; i++)
            send(i);
        chk({17'h0, queue_full_out}, 24'h7f, "full");
        send(11);
        stall = 1'b0;
        slow  = 1'b0;
        for (int i = 1; i <= 10; i++)
        begin
            step(0, i);
            step(1, i);
        end
        repeat (8) @(posedge ref_clk_in);
        #1;
        chk({23'h0, board_valid_out}, 24'h0, "drained");
        $display("test fill and drain done");
        hwr(0, 17'h00003, 16'hab00, 0, 7'h08);
        hwr(0, 17'h00000, 16'h00cd, 1, 7'h01);
        hwr(0, 17'h00006, 16'hffff, 0, 7'h00);
        idle;
        rst(2);
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk({23'h0, board_valid_out}, 24'h0, "partial");
        // stale single bytes must be gone, or this entry comes out shifted
        hwr(1, 17'h00336, 16'h0002, 0, 7'h0);
        send(12);
        step(0, 12);
        step(1, 12);
        $display("test single bytes and reset done");
        finish_test;
    end
endmodule // testbench

`default_nettype wire
